/* rtl/iml_map.svh */
`ifndef IML_MAP_SVH
`define IML_MAP_SVH
// Fixed lane figures
`define IML_LINE_RATE_MBPS 1250
`define IML_REFCLK_MHZ     100
// Symbols: K flag travels beside the byte
`define IML_K_START        8'h3C
`define IML_K_IDLE         8'hBC
`define IML_CRC_POLY       8'h07
`define IML_CRC_INIT       8'h00
// CRC byte index after the start symbol
`define IML_CRC_IDX        3'h5
`define IML_SYNC_IDLES     3'h4
// Idles before the first frame
`define IML_TX_LEAD        4'h8
`define IML_CTL_STATUS     8'h80
`define IML_CTL_STAT_ACK   8'hC0
`define IML_CTL_REQ        2'b00
`define IML_CTL_RESP       2'b01
`define IML_CTL_WR_BIT     5
`define IML_SPEED_10       2'b00
// Controller register map
`define IML_REG_REQ        8'h00
`define IML_REG_WDATA      8'h04
`define IML_REG_RDATA      8'h08
`define IML_REG_STAT       8'h0C
`define IML_REG_CFG        8'h10
`define IML_CFG_RST        2'h3
`endif

/* rtl/iml_pkg.sv */
package iml_pkg;
  `include "iml_map.svh"

  typedef enum logic [2:0] {
    IML_TX_OFF   = 3'b001,
    IML_TX_IDLE  = 3'b010,
    IML_TX_FRAME = 3'b100
  } iml_tx_state_type;

  // Lane word: [9] link clock, [8] K flag, [7:0] byte
  typedef logic [9:0] iml_lane_type;

  function automatic logic [7:0] iml_crc8(input logic [7:0] crc,
                                          input logic [7:0] din);
    logic [7:0] c;
    c = crc ^ din;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `IML_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
endpackage

/* rtl/iml_if.sv */
`timescale 1ns/1ps
interface iml_if;
  import iml_pkg::*;
  iml_lane_type icx_p2m;
  iml_lane_type icx_m2p;
  iml_lane_type mgt_p2m;
  iml_lane_type mgt_m2p;
  logic         power_clock_good_n;
  logic         refclk_request_n;

  modport phy (
    input  icx_m2p,
    input  mgt_m2p,
    input  power_clock_good_n,
    output icx_p2m,
    output mgt_p2m,
    output refclk_request_n
  );
  modport mac (
    input  icx_p2m,
    input  mgt_p2m,
    input  refclk_request_n,
    output icx_m2p,
    output mgt_m2p,
    output power_clock_good_n
  );
endinterface

/* rtl/iml_phy_end.sv */
`timescale 1ns/1ps
`include "iml_map.svh"
// Operation
// R1 - Serial lane awake, management lane asleep
// R2 - Report 10 Mb/s speed while asleep
// R3 - One lane each way, fixed rate
// R4 - Only whole frames cross the link; a frame in flight is cut off when the lane switches or power good drops
// R5 - Idles after power-up, receiver syncs
// R6 - Device originates status only, awaits ack
// R7 - Resend unacked status after lane switch
// R8 - Start symbol first, CRC-8 last
// R9 - Request control byte: 00, rw, register
// R10 - Request data MSB first, zero on read
// R11 - Request device address in bits 4:0
// R12 - Response echoes rw and register number
// R13 - Status on change or interval expiry
// R14 - Retransmit status after ack timeout
// R15 - Status control byte is 80h
// R16 - Status byte one field layout
// R17 - Status byte two upper field layout
// R18 - Duplex bit and speed code
// R19 - Power good in, clock request out
// R20 - Controller ack control byte C0h
// R21 - Drop frames failing CRC check
module iml_phy_end
  import iml_pkg::*;
#(
  parameter int TMR_W = 16
) (
  iml_if.phy               lnk,
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  input  wire logic        i_sleep,
  input  wire logic        i_host_wake,
  input  wire logic        i_ei_req,
  input  wire logic        i_txoff_req,
  input  wire logic        i_lpl_req,
  input  wire logic        i_reset_done,
  input  wire logic        i_cable_disc,
  input  wire logic        i_line_up,
  input  wire logic        i_full_duplex,
  input  wire logic [1:0]  i_line_speed,
  input  wire logic [TMR_W-1:0] i_status_interval,
  input  wire logic [TMR_W-1:0] i_ack_timeout,
  input  wire logic        i_refclk_needed,
  input  wire logic [15:0] i_reg_rdata,
  output logic             o_reg_req,
  output logic             o_reg_wr,
  output logic [4:0]       o_reg_num,
  output logic [4:0]       o_reg_dev,
  output logic [15:0]      o_reg_wdata,
  output logic [1:0]       o_line_speed,
  output logic             o_mgmt_active,
  output logic             o_icx_link_up,
  output logic             o_ack_pending
);
  logic [1:0]       pcg_n_s_r;
  logic             pcg_ok;
  logic             mgt_mode_r;
  logic             mode_chg;
  iml_lane_type     icx_s1_r, icx_s2_r, mgt_s1_r, mgt_s2_r;
  iml_lane_type     rx_lane;
  logic             rx_clk_d_r;
  logic             rx_rise;
  logic [2:0]       rx_idx_r;
  logic [7:0]       rx_crc_r;
  logic [31:0]      rx_buf_r;
  logic [2:0]       idle_cnt_r;
  logic             rx_sync_r;
  logic             frame_ok_r;
  logic             is_req, is_sack;
  logic             rd_cap_r;
  logic [31:0]      resp_msg_r;
  logic             resp_pend_r;
  logic [15:0]      stat_last_r;
  logic [7:0]       stat_b1, stat_b2;
  logic [1:0]       speed_eff;
  logic             stat_pend_r;
  logic             ack_wait_r;
  logic [TMR_W-1:0] ack_tmr_r, ivl_tmr_r;
  logic             retx_hit, ivl_hit;
  logic [2:0]       div_r;
  logic             tick;
  iml_tx_state_type tx_st_r;
  logic [2:0]       tx_idx_r;
  logic [31:0]      tx_msg_r;
  logic [7:0]       tx_crc_r, tx_byte_r;
  logic             tx_k_r;
  logic [3:0]       lead_r;
  logic             tx_take, take_resp, take_stat;
  iml_lane_type     icx_out_r, mgt_out_r;
  logic             refclk_n_r;

  // Platform input: two flops first
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pcg_n_s_r <= 2'b11;
    end else begin
      pcg_n_s_r <= {pcg_n_s_r[0], lnk.power_clock_good_n}; // R19
    end
  end
  assign pcg_ok = ~pcg_n_s_r[1];

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mgt_mode_r <= 1'b0;
      refclk_n_r <= 1'b0;
    end else begin
      mgt_mode_r <= i_sleep; // R1
      refclk_n_r <= ~i_refclk_needed; // R19
    end
  end
  assign mode_chg = i_sleep ^ mgt_mode_r;

  // Both lanes synced; active one decoded
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      icx_s1_r <= 10'h000;
      icx_s2_r <= 10'h000;
      mgt_s1_r <= 10'h000;
      mgt_s2_r <= 10'h000;
    end else begin
      icx_s1_r <= lnk.icx_m2p;
      icx_s2_r <= icx_s1_r;
      mgt_s1_r <= lnk.mgt_m2p;
      mgt_s2_r <= mgt_s1_r;
    end
  end
  assign rx_lane = mgt_mode_r ? mgt_s2_r : icx_s2_r; // R1
  assign rx_rise = rx_lane[9] & ~rx_clk_d_r;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_clk_d_r <= 1'b0;
      rx_idx_r   <= 3'h0;
      rx_crc_r   <= 8'h00;
      rx_buf_r   <= 32'h0000_0000;
      idle_cnt_r <= 3'h0;
      rx_sync_r  <= 1'b0;
      frame_ok_r <= 1'b0;
    end else begin
      rx_clk_d_r <= rx_lane[9];
      frame_ok_r <= 1'b0;
      if (!pcg_ok || mode_chg) begin
        rx_idx_r   <= 3'h0;
        idle_cnt_r <= 3'h0;
        rx_sync_r  <= 1'b0;
      end else if (rx_rise) begin
        if (rx_lane[8] && rx_lane[7:0] == `IML_K_IDLE) begin
          rx_idx_r <= 3'h0;
          if (!rx_sync_r) begin
            idle_cnt_r <= idle_cnt_r + 3'h1;
            rx_sync_r  <= (idle_cnt_r == `IML_SYNC_IDLES - 3'h1); // R5
          end
        end else if (!rx_sync_r) begin
          idle_cnt_r <= 3'h0;
        end else if (rx_lane[8] && rx_lane[7:0] == `IML_K_START) begin
          rx_idx_r <= 3'h1; // R8
          rx_crc_r <= `IML_CRC_INIT;
        end else if (rx_lane[8]) begin
          rx_idx_r <= 3'h0;
        end else if (rx_idx_r == `IML_CRC_IDX) begin
          frame_ok_r <= (rx_lane[7:0] == rx_crc_r); // R21
          rx_idx_r   <= 3'h0;
        end else if (rx_idx_r != 3'h0) begin
          rx_buf_r <= {rx_buf_r[23:0], rx_lane[7:0]};
          rx_crc_r <= iml_crc8(rx_crc_r, rx_lane[7:0]); // R8
          rx_idx_r <= rx_idx_r + 3'h1;
        end
      end
    end
  end

  assign is_req  = frame_ok_r && rx_buf_r[31:30] == `IML_CTL_REQ; // R9
  assign is_sack = frame_ok_r && rx_buf_r[31:24] == `IML_CTL_STAT_ACK; // R20

  // Register access: read data is taken one cycle after the strobe
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_req   <= 1'b0;
      o_reg_wr    <= 1'b0;
      o_reg_num   <= 5'h00;
      o_reg_dev   <= 5'h00;
      o_reg_wdata <= 16'h0000;
      rd_cap_r    <= 1'b0;
      resp_msg_r  <= 32'h0000_0000;
    end else begin
      o_reg_req <= is_req;
      rd_cap_r  <= o_reg_req;
      if (is_req) begin
        o_reg_wr    <= rx_buf_r[24 + `IML_CTL_WR_BIT]; // R9
        o_reg_num   <= rx_buf_r[28:24];
        o_reg_wdata <= rx_buf_r[23:8]; // R10
        o_reg_dev   <= rx_buf_r[4:0]; // R11
      end
      if (rd_cap_r) begin
        resp_msg_r <= {`IML_CTL_RESP, o_reg_wr, o_reg_num,
                       o_reg_wr ? o_reg_wdata : i_reg_rdata, 8'h00}; // R12
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      resp_pend_r <= 1'b0;
    end else if (!pcg_ok) begin
      resp_pend_r <= 1'b0;
    end else begin
      resp_pend_r <= rd_cap_r | (resp_pend_r & ~take_resp);
    end
  end

  assign speed_eff = mgt_mode_r ? `IML_SPEED_10 : i_line_speed; // R2
  assign stat_b1 = {2'b00, i_host_wake, 2'b00,
                    i_ei_req, i_txoff_req, i_lpl_req}; // R16
  assign stat_b2 = {i_reset_done, 1'b0, o_icx_link_up,
                    i_cable_disc, i_line_up, // R17
                    i_full_duplex, speed_eff}; // R18
  assign ivl_hit  = (i_status_interval != '0) &&
                    (ivl_tmr_r == i_status_interval);
  assign retx_hit = ack_wait_r && (i_ack_timeout != '0) &&
                    (ack_tmr_r == i_ack_timeout);

  // Set wins over take
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stat_last_r <= 16'h0000;
      stat_pend_r <= 1'b0;
      ack_wait_r  <= 1'b0;
      ack_tmr_r   <= '0;
      ivl_tmr_r   <= '0;
    end else if (!pcg_ok) begin
      stat_last_r <= 16'h0000;
      stat_pend_r <= 1'b0;
      ack_wait_r  <= 1'b0;
      ack_tmr_r   <= '0;
      ivl_tmr_r   <= '0;
    end else begin
      stat_last_r <= {stat_b1, stat_b2};
      stat_pend_r <= ({stat_b1, stat_b2} != stat_last_r) | ivl_hit // R13
                   | retx_hit // R14
                   | (mode_chg & ack_wait_r) // R7
                   | (stat_pend_r & ~take_stat);
      ack_wait_r  <= take_stat | (ack_wait_r & ~is_sack); // R6
      ack_tmr_r   <= (take_stat || !ack_wait_r || retx_hit) ? '0
                     : ack_tmr_r + 1'b1;
      ivl_tmr_r   <= (take_stat || ivl_hit) ? '0 : ivl_tmr_r + 1'b1;
    end
  end

  // Eight system clocks per link symbol
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end
  assign tick = (div_r == 3'h7);
  // Response first: reads never starve
  assign tx_take   = tick && tx_st_r == IML_TX_IDLE && !mode_chg &&
                     lead_r == `IML_TX_LEAD;
  assign take_resp = tx_take & resp_pend_r;
  assign take_stat = tx_take & ~resp_pend_r & stat_pend_r; // R6

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_st_r   <= IML_TX_OFF;
      tx_idx_r  <= 3'h0;
      tx_msg_r  <= 32'h0000_0000;
      tx_crc_r  <= 8'h00;
      tx_byte_r <= 8'h00;
      tx_k_r    <= 1'b0;
      lead_r    <= 4'h0;
    end else if (!pcg_ok || mode_chg) begin
      tx_st_r <= IML_TX_OFF; // R1
      lead_r  <= 4'h0;
    end else if (tick) begin
      unique case (tx_st_r)
        IML_TX_OFF: begin
          tx_st_r   <= IML_TX_IDLE;
          tx_byte_r <= `IML_K_IDLE; // R5
          tx_k_r    <= 1'b1;
        end
        IML_TX_IDLE: begin
          tx_k_r <= 1'b1;
          if (take_resp || take_stat) begin
            tx_st_r   <= IML_TX_FRAME;
            tx_byte_r <= `IML_K_START; // R8
            tx_crc_r  <= `IML_CRC_INIT;
            tx_idx_r  <= 3'h1;
            tx_msg_r  <= take_resp ? resp_msg_r
                         : {`IML_CTL_STATUS, stat_b1, stat_b2, 8'h00}; // R15
          end else begin
            tx_byte_r <= `IML_K_IDLE;
            if (lead_r != `IML_TX_LEAD) begin
              lead_r <= lead_r + 4'h1;
            end
          end
        end
        IML_TX_FRAME: begin
          tx_k_r <= 1'b0;
          if (tx_idx_r == `IML_CRC_IDX) begin
            tx_byte_r <= tx_crc_r; // R8
            tx_st_r   <= IML_TX_IDLE;
          end else begin
            tx_byte_r <= tx_msg_r[31:24];
            tx_crc_r  <= iml_crc8(tx_crc_r, tx_msg_r[31:24]);
            tx_msg_r  <= {tx_msg_r[23:0], 8'h00};
            tx_idx_r  <= tx_idx_r + 3'h1;
          end
        end
        default: tx_st_r <= IML_TX_OFF;
      endcase
    end
  end

  // Unused lane parked low
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      icx_out_r <= 10'h000;
      mgt_out_r <= 10'h000;
    end else begin
      icx_out_r <= (pcg_ok && !mgt_mode_r && tx_st_r != IML_TX_OFF)
                   ? {div_r[2], tx_k_r, tx_byte_r} : 10'h000; // R3 R4
      mgt_out_r <= (pcg_ok && mgt_mode_r && tx_st_r != IML_TX_OFF)
                   ? {div_r[2], tx_k_r, tx_byte_r} : 10'h000; // R1
    end
  end

  assign lnk.icx_p2m          = icx_out_r;
  assign lnk.mgt_p2m          = mgt_out_r;
  assign lnk.refclk_request_n = refclk_n_r;
  assign o_line_speed  = speed_eff;
  assign o_mgmt_active = mgt_mode_r;
  assign o_icx_link_up = rx_sync_r & ~mgt_mode_r;
  assign o_ack_pending = ack_wait_r;
endmodule

/* rtl/iml_mac_end.sv */
`timescale 1ns/1ps
`include "iml_map.svh"
module iml_mac_end
  import iml_pkg::*;
(
  iml_if.mac               lnk,
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  input  wire logic        i_sleep,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  output logic             o_refclk_req
);
  logic [1:0]       clkreq_s_r;
  logic             mgt_mode_r, mode_chg;
  iml_lane_type     icx_s1_r, icx_s2_r, mgt_s1_r, mgt_s2_r;
  iml_lane_type     rx_lane;
  logic             rx_clk_d_r, rx_rise;
  logic [2:0]       rx_idx_r;
  logic [7:0]       rx_crc_r;
  logic [31:0]      rx_buf_r;
  logic [2:0]       idle_cnt_r;
  logic             rx_sync_r, frame_ok_r;
  logic             is_stat, is_resp, req_wr;
  logic [12:0]      req_r;
  logic [15:0]      wdata_r, rdata_r, stat_r;
  logic [1:0]       cfg_r;
  logic             done_r, req_pend_r, resp_wait_r, ack_pend_r;
  logic [2:0]       div_r;
  logic             tick, tx_take, take_ack, take_req;
  iml_tx_state_type tx_st_r;
  logic [2:0]       tx_idx_r;
  logic [31:0]      tx_msg_r;
  logic [7:0]       tx_crc_r, tx_byte_r;
  logic             tx_k_r;
  logic [3:0]       lead_r;
  iml_lane_type     icx_out_r, mgt_out_r;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      clkreq_s_r <= 2'b11;
      mgt_mode_r <= 1'b0;
      icx_s1_r   <= 10'h000;
      icx_s2_r   <= 10'h000;
      mgt_s1_r   <= 10'h000;
      mgt_s2_r   <= 10'h000;
    end else begin
      clkreq_s_r <= {clkreq_s_r[0], lnk.refclk_request_n};
      mgt_mode_r <= i_sleep;
      icx_s1_r   <= lnk.icx_p2m;
      icx_s2_r   <= icx_s1_r;
      mgt_s1_r   <= lnk.mgt_p2m;
      mgt_s2_r   <= mgt_s1_r;
    end
  end
  assign mode_chg = i_sleep ^ mgt_mode_r;
  assign rx_lane  = mgt_mode_r ? mgt_s2_r : icx_s2_r;
  assign rx_rise  = rx_lane[9] & ~rx_clk_d_r;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_clk_d_r <= 1'b0;
      rx_idx_r   <= 3'h0;
      rx_crc_r   <= 8'h00;
      rx_buf_r   <= 32'h0000_0000;
      idle_cnt_r <= 3'h0;
      rx_sync_r  <= 1'b0;
      frame_ok_r <= 1'b0;
    end else begin
      rx_clk_d_r <= rx_lane[9];
      frame_ok_r <= 1'b0;
      if (!cfg_r[1] || mode_chg) begin
        rx_idx_r   <= 3'h0;
        idle_cnt_r <= 3'h0;
        rx_sync_r  <= 1'b0;
      end else if (rx_rise) begin
        if (rx_lane[8] && rx_lane[7:0] == `IML_K_IDLE) begin
          rx_idx_r <= 3'h0;
          if (!rx_sync_r) begin
            idle_cnt_r <= idle_cnt_r + 3'h1;
            rx_sync_r  <= (idle_cnt_r == `IML_SYNC_IDLES - 3'h1);
          end
        end else if (!rx_sync_r) begin
          idle_cnt_r <= 3'h0;
        end else if (rx_lane[8] && rx_lane[7:0] == `IML_K_START) begin
          rx_idx_r <= 3'h1;
          rx_crc_r <= `IML_CRC_INIT;
        end else if (rx_lane[8]) begin
          rx_idx_r <= 3'h0;
        end else if (rx_idx_r == `IML_CRC_IDX) begin
          frame_ok_r <= (rx_lane[7:0] == rx_crc_r);
          rx_idx_r   <= 3'h0;
        end else if (rx_idx_r != 3'h0) begin
          rx_buf_r <= {rx_buf_r[23:0], rx_lane[7:0]};
          rx_crc_r <= iml_crc8(rx_crc_r, rx_lane[7:0]);
          rx_idx_r <= rx_idx_r + 3'h1;
        end
      end
    end
  end
  assign is_stat = frame_ok_r && rx_buf_r[31:24] == `IML_CTL_STATUS;
  assign is_resp = frame_ok_r && rx_buf_r[31:30] == `IML_CTL_RESP;
  assign req_wr  = i_wr && i_addr == `IML_REG_REQ;

  // Hardware sets win over clears
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      req_r       <= 13'h0000;
      wdata_r     <= 16'h0000;
      cfg_r       <= `IML_CFG_RST;
      rdata_r     <= 16'h0000;
      stat_r      <= 16'h0000;
      done_r      <= 1'b0;
      req_pend_r  <= 1'b0;
      resp_wait_r <= 1'b0;
      ack_pend_r  <= 1'b0;
    end else begin
      if (req_wr) begin
        req_r <= i_wdata[12:0];
      end
      if (i_wr && i_addr == `IML_REG_WDATA) begin
        wdata_r <= i_wdata[15:0];
      end
      if (i_wr && i_addr == `IML_REG_CFG) begin
        cfg_r <= i_wdata[1:0];
      end
      if (is_resp) begin
        rdata_r <= rx_buf_r[23:8];
      end
      if (is_stat) begin
        stat_r <= rx_buf_r[23:8];
      end
      done_r      <= is_resp | (done_r & ~req_wr);
      req_pend_r  <= req_wr | (req_pend_r & ~take_req);
      resp_wait_r <= take_req | (resp_wait_r & ~is_resp);
      ack_pend_r  <= (is_stat & cfg_r[0]) | (ack_pend_r & ~take_ack);
    end
  end

  // Read data stands one cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 32'h0000_0000;
    end else if (!i_rd) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      unique case (i_addr)
        `IML_REG_REQ:   o_rdata <= {19'h0_0000, req_r};
        `IML_REG_WDATA: o_rdata <= {16'h0000, wdata_r};
        `IML_REG_RDATA: o_rdata <= {15'h0000, done_r, rdata_r};
        `IML_REG_STAT:  o_rdata <= {13'h0000, ~clkreq_s_r[1], rx_sync_r,
                                    req_pend_r | resp_wait_r, stat_r};
        `IML_REG_CFG:   o_rdata <= {30'h0000_0000, cfg_r};
        default:        o_rdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end
  assign tick     = (div_r == 3'h7);
  assign tx_take  = tick && tx_st_r == IML_TX_IDLE && !mode_chg &&
                    lead_r == `IML_TX_LEAD;
  assign take_ack = tx_take & ack_pend_r;
  assign take_req = tx_take & ~ack_pend_r & req_pend_r;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_st_r   <= IML_TX_OFF;
      tx_idx_r  <= 3'h0;
      tx_msg_r  <= 32'h0000_0000;
      tx_crc_r  <= 8'h00;
      tx_byte_r <= 8'h00;
      tx_k_r    <= 1'b0;
      lead_r    <= 4'h0;
    end else if (!cfg_r[1] || mode_chg) begin
      tx_st_r <= IML_TX_OFF;
      lead_r  <= 4'h0;
    end else if (tick) begin
      unique case (tx_st_r)
        IML_TX_OFF: begin
          tx_st_r   <= IML_TX_IDLE;
          tx_byte_r <= `IML_K_IDLE;
          tx_k_r    <= 1'b1;
        end
        IML_TX_IDLE: begin
          tx_k_r <= 1'b1;
          if (take_ack || take_req) begin
            tx_st_r   <= IML_TX_FRAME;
            tx_byte_r <= `IML_K_START;
            tx_crc_r  <= `IML_CRC_INIT;
            tx_idx_r  <= 3'h1;
            tx_msg_r  <= take_ack ? {`IML_CTL_STAT_ACK, 24'h00_0000}
                         : {`IML_CTL_REQ, req_r[5:0],
                            req_r[5] ? wdata_r : 16'h0000,
                            3'b000, req_r[12:8]};
          end else begin
            tx_byte_r <= `IML_K_IDLE;
            if (lead_r != `IML_TX_LEAD) begin
              lead_r <= lead_r + 4'h1;
            end
          end
        end
        IML_TX_FRAME: begin
          tx_k_r <= 1'b0;
          if (tx_idx_r == `IML_CRC_IDX) begin
            tx_byte_r <= tx_crc_r;
            tx_st_r   <= IML_TX_IDLE;
          end else begin
            tx_byte_r <= tx_msg_r[31:24];
            tx_crc_r  <= iml_crc8(tx_crc_r, tx_msg_r[31:24]);
            tx_msg_r  <= {tx_msg_r[23:0], 8'h00};
            tx_idx_r  <= tx_idx_r + 3'h1;
          end
        end
        default: tx_st_r <= IML_TX_OFF;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      icx_out_r <= 10'h000;
      mgt_out_r <= 10'h000;
    end else begin
      icx_out_r <= (!mgt_mode_r && tx_st_r != IML_TX_OFF)
                   ? {div_r[2], tx_k_r, tx_byte_r} : 10'h000;
      mgt_out_r <= (mgt_mode_r && tx_st_r != IML_TX_OFF)
                   ? {div_r[2], tx_k_r, tx_byte_r} : 10'h000;
    end
  end

  assign lnk.icx_m2p            = icx_out_r;
  assign lnk.mgt_m2p            = mgt_out_r;
  assign lnk.power_clock_good_n = ~cfg_r[1];
  assign o_refclk_req           = ~clkreq_s_r[1];
endmodule

/* dv/iml_link_chk.sv */
`timescale 1ns/1ps
module iml_link_chk
  import iml_pkg::*;
(
  input wire logic         i_clk_sys,
  input wire logic         i_rst_b,
  input wire iml_lane_type icx_p2m,
  input wire iml_lane_type icx_m2p
);
  iml_lane_type ln [2];
  logic [8:0]   s_r [2][6];
  logic [1:0]   ck_r, fe_r;
  logic [31:0]  pd, md;
  assign ln = '{icx_p2m, icx_m2p};
  assign pd = {s_r[0][4][7:0], s_r[0][3][7:0], s_r[0][2][7:0], s_r[0][1][7:0]};
  assign md = {s_r[1][4][7:0], s_r[1][3][7:0], s_r[1][2][7:0], s_r[1][1][7:0]};
  // A K in the window marks an aborted frame
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ck_r <= '0;
      fe_r <= '0;
      s_r  <= '{default: '0};
    end else begin
      for (int d = 0; d < 2; d++) begin
        ck_r[d] <= ln[d][9];
        fe_r[d] <= 1'b0;
        if (ln[d][9] && !ck_r[d]) begin
          for (int k = 5; k > 0; k--) s_r[d][k] <= s_r[d][k-1];
          s_r[d][0] <= ln[d][8:0];
          fe_r[d] <= s_r[d][4] == 9'h13C && !s_r[d][3][8] && !s_r[d][2][8]
                     && !s_r[d][1][8] && !s_r[d][0][8] && !ln[d][8];
        end
      end
    end
  end
  function automatic logic crc_ok(input int d);
    logic [7:0] c;
    c = 8'h00;
    for (int b = 4; b > 0; b--) begin
      c = c ^ s_r[d][b][7:0];
      for (int i = 0; i < 8; i++)
        c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
    end
    return c == s_r[d][0][7:0];
  endfunction
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  sequence s_sym_hi;
    icx_p2m[9] ##1 icx_p2m[9];
  endsequence
  a_sym_hold: assert property (s_sym_hi |-> $stable(icx_p2m[8:0]))
    else $error("symbol changed while link clock high");
  a_k_codes: assert property (icx_p2m[8] |-> icx_p2m[7:0] inside {8'h3C, 8'hBC})
    else $error("unknown control symbol");
  a_crc_dev: assert property (fe_r[0] |-> crc_ok(0))
    else $error("bad check byte from device end");
  a_crc_mac: assert property (fe_r[1] |-> crc_ok(1))
    else $error("bad check byte from controller end");
  a_stat_fmt: assert property (fe_r[0] && pd[31] |-> pd[31:24] == 8'h80 &&
    (pd[23:16] & 8'hD8) == 0 && pd[9:8] != 2'b11 && pd[7:0] == 0)
    else $error("status frame layout wrong");
  a_resp_fmt: assert property (fe_r[0] && !pd[31] |-> pd[30] && pd[7:0] == 0)
    else $error("response frame layout wrong");
  a_ack_fmt: assert property (fe_r[1] && md[31] |-> md == 32'hC0000000)
    else $error("acknowledge frame layout wrong");
  a_req_fmt: assert property (fe_r[1] && !md[31] |-> !md[30] && md[7:5] == 0
    && (md[29] || md[23:8] == 0))
    else $error("request frame layout wrong");
endmodule

/* dv/tb_inband_message_link.sv */
`timescale 1ns/1ps
module tb_inband_message_link;
  logic        clk = 0, rst_b = 0, slp = 0, need = 0, wr = 0, rd = 0;
  logic        rq, rwo, mga, pend, rck;
  logic [1:0]  lsp, pc = '0;
  logic [4:0]  rn, rdv;
  logic [7:0]  addr = '0;
  logic [9:0]  st = '0;
  logic [15:0] rdat = '0, rwd;
  logic [31:0] wdat = '0, rv, ord;
  logic [47:0] rows [3] = '{48'h0325_A55A_0000, 48'h1F1F_BEEF_1234,
                            48'h0020_FFFF_8001};
  int          err_count = 0, num_checks = 0, nic = 0, nmg = 0, n;
  always #4 clk = ~clk;
  iml_if lnk_i ();
  // Frame starts per lane
  always @(posedge clk) begin
    pc <= {lnk_i.icx_p2m[9], lnk_i.mgt_p2m[9]};
    if (lnk_i.icx_p2m == 10'h33C && !pc[1]) nic++;
    if (lnk_i.mgt_p2m == 10'h33C && !pc[0]) nmg++;
  end
  iml_phy_end #(.TMR_W(16)) iml_phy_end_i (.lnk(lnk_i), .i_clk_sys(clk),
    .i_rst_b(rst_b), .i_sleep(slp), .i_host_wake(st[9]), .i_ei_req(st[8]),
    .i_txoff_req(st[7]), .i_lpl_req(st[6]), .i_reset_done(st[5]),
    .i_cable_disc(st[4]), .i_line_up(st[3]), .i_full_duplex(st[2]),
    .i_line_speed(st[1:0]), .i_status_interval(16'h0000),
    .i_ack_timeout(16'h00C8), .i_refclk_needed(need), .i_reg_rdata(rdat),
    .o_reg_req(rq), .o_reg_wr(rwo), .o_reg_num(rn), .o_reg_dev(rdv),
    .o_reg_wdata(rwd), .o_line_speed(lsp), .o_mgmt_active(mga),
    .o_icx_link_up(), .o_ack_pending(pend));
  iml_mac_end iml_mac_end_i (.lnk(lnk_i), .i_clk_sys(clk), .i_rst_b(rst_b),
    .i_sleep(slp), .i_addr(addr), .i_wdata(wdat), .i_wr(wr), .i_rd(rd),
    .o_rdata(ord), .o_refclk_req(rck));
  iml_link_chk iml_link_chk_i (.i_clk_sys(clk), .i_rst_b(rst_b),
    .icx_p2m(lnk_i.icx_p2m), .icx_m2p(lnk_i.icx_m2p));
  task automatic chk(input logic [31:0] g, input logic [31:0] e, string m);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 rv = ord;
    @(posedge clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk);
    chk({lnk_i.icx_p2m, lnk_i.power_clock_good_n, ord}, '0, "reset");
    rst_b <= 1'b1;
    @(posedge clk);
    rd_reg(8'h10);
    chk(rv, 32'h0000_0003, "config reset value");
    rd_reg(8'h20);
    chk(rv, '0, "unmapped read");
    need <= 1'b1;
    repeat (8) @(posedge clk);
    chk(rck, 1'b1, "clock request");
    $display("reset test done");
    for (int i = 0; i < 3; i++) begin
      rdat <= rows[i][15:0];
      wr_reg(8'h04, {16'h0000, rows[i][31:16]});
      wr_reg(8'h00, {16'h0000, rows[i][47:32]});
      n = 0;
      do @(posedge clk); while (rq !== 1'b1 && ++n < 600);
      chk({rwo, rn, rdv, rwd}, {rows[i][37], rows[i][36:32], rows[i][44:40],
          rows[i][37] ? rows[i][31:16] : 16'h0000}, "request fields");
      n = 0;
      do rd_reg(8'h08); while (rv[16] !== 1'b1 && ++n < 60);
      chk(rv[16:0], {1'b1, rows[i][37] ? rows[i][31:16] : rows[i][15:0]},
          "reply");
    end
    $display("register access test done");
    for (int k = 0; k < 3; k++) begin
      st <= {k[0], ~k[0], k[1], 2'b11, k[0], ~k[0], k[1], k[1:0]};
      repeat (700) @(posedge clk);
      rd_reg(8'h0C);
      chk(rv[15:0], {2'b00, st[9], 2'b00, st[8:5], 2'b01, st[4:0]}, "status");
      chk(pend, 1'b0, "status acknowledged");
    end
    $display("status test done");
    wr_reg(8'h10, 32'h0000_0002);
    n = nic;
    st[1:0] <= 2'b01;
    repeat (1000) @(posedge clk);
    chk({pend, nic - n > 2}, 2'b11, "resend without ack");
    slp <= 1'b1;
    n = nmg;
    repeat (600) @(posedge clk);
    chk({mga, lsp, lnk_i.icx_p2m, nmg > n}, 14'h2001, "sleep lane");
    wr_reg(8'h10, 32'h0000_0003);
    repeat (800) @(posedge clk);
    chk(pend, 1'b0, "acknowledged while asleep");
    $display("sleep test done");
    report_and_stop();
  end
endmodule
